// ### bench/scd_engine_model.sv
/*
  Erase engine model on the decoder's operation port: logs each
  finished operation and answers promptly and slowly by turns.
  Assumes the decoder's clock and synchronous reset.
*/
`timescale 1ns/10ps

module scd_engine_model
  import scd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire scd_op_t op_kind_in,
  input wire logic [7:0] op_fill_in,
  output logic op_done_out
);
  logic [9:0] log_q [0:63]; // kind and byte of finished operations
  int n_ops; // operations finished since reset
  int cnt; // cycles spent on the current operation

  // one done pulse per request; the byte is kept only for a fixed
  // fill, since it means nothing for the other kinds
  always @(posedge clk_in)
  begin
    op_done_out <= 1'b0;
    if (rst_in)
    begin
      n_ops <= 0;
      cnt <= 0;
    end
    else if (op_valid_in && !op_done_out)
    begin
      if (cnt >= (n_ops % 2) * 3)
      begin
        op_done_out <= 1'b1;
        log_q[n_ops % 64] <= {op_kind_in,
          (op_kind_in == OPK_FILL_BYTE) ? op_fill_in : 8'h00};
        n_ops <= n_ops + 1;
        cnt <= 0;
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule

// ### bench/scd_top_asserts.sv
/*
  Port checker for the sanitize command decoder top.
  Assumes a bind to scd_top and a single clock domain.
*/
`timescale 1ns/10ps

module scd_top_asserts
  import scd_pkg::*;
#(
  parameter int NPART = 8
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic OP_DONE_IN,
  input wire logic OP_VALID_OUT,
  input wire scd_op_t OP_KIND_OUT,
  input wire logic [7:0] OP_FILL_OUT,
  input wire logic [NPART-1:0] OP_MASK_OUT,
  input wire logic OP_WHOLE_OUT,
  input wire logic RETAIN_DEFECTS_OUT,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT
);
  default clocking dc @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  scd_op_t last_kind; // kind of the last finished operation

  // remembers what the engine just finished; reset to a fill so that
  // a fill as very first operation is caught
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      last_kind <= OPK_FILL_RND;
    else if (OP_VALID_OUT && OP_DONE_IN)
      last_kind <= OP_KIND_OUT;
  end

  sequence acc_wait; // first access cycle, no answer yet
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  sequence ready_once; // answer stands exactly one cycle
    PREADY_OUT ##1 !PREADY_OUT;
  endsequence

  apb_one_wait_a:
    assert property (acc_wait |=> ready_once)
    else $error("bus access not answered after one wait");
  op_hold_a:
    assert property (OP_VALID_OUT && !OP_DONE_IN |=>
      OP_VALID_OUT && $stable(OP_KIND_OUT) && $stable(OP_FILL_OUT))
    else $error("operation changed before the engine finished");
  op_drop_a:
    assert property (OP_VALID_OUT && OP_DONE_IN |=> !OP_VALID_OUT)
    else $error("operation request held after completion");
  erase_first_a:
    assert property ($rose(OP_VALID_OUT) && OP_KIND_OUT != OPK_ERASE
      |-> last_kind == OPK_ERASE)
    else $error("fill issued without an erase before it");
  valid_busy_a:
    assert property (OP_VALID_OUT |-> BUSY_OUT)
    else $error("operation requested while not busy");
  done_end_a:
    assert property (DONE_OUT |-> !OP_VALID_OUT ##1
      (!DONE_OUT && !BUSY_OUT))
    else $error("completion pulse wrong or busy kept");
  whole_mask_a:
    assert property (BUSY_OUT |-> OP_WHOLE_OUT == (OP_MASK_OUT == '0))
    else $error("whole media flag disagrees with mask");
  retain_set_a:
    assert property ($changed(RETAIN_DEFECTS_OUT) |-> ##[0:3] BUSY_OUT)
    else $error("retention flag changed outside a sanitize");
endmodule

bind scd_top scd_top_asserts #(.NPART(NPART)) chk_i (
  .CLK_IN(CLK_IN),
  .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN),
  .PREADY_OUT(PREADY_OUT),
  .OP_DONE_IN(OP_DONE_IN),
  .OP_VALID_OUT(OP_VALID_OUT),
  .OP_KIND_OUT(OP_KIND_OUT),
  .OP_FILL_OUT(OP_FILL_OUT),
  .OP_MASK_OUT(OP_MASK_OUT),
  .OP_WHOLE_OUT(OP_WHOLE_OUT),
  .RETAIN_DEFECTS_OUT(RETAIN_DEFECTS_OUT),
  .BUSY_OUT(BUSY_OUT),
  .DONE_OUT(DONE_OUT)
);

// ### bench/tb.sv
/*
  Bench for the sanitize command decoder: apb host tasks, command
  sequences, expected replies and engine operations.
  Assumes the decoder, its checker and the engine model are compiled.
*/
`timescale 1ns/10ps
`include "scd_defs.svh"

module tb;
  localparam logic [9:0] ER = 10'h000; // erase
  localparam logic [9:0] RN = 10'h200; // random fill
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, op_done, opv, whole, ret, busy, sdone;
  scd_pkg::scd_op_t kind; // operation kind, typed like both ports
  logic [7:0] fill, mask;
  logic [31:0] rq; // last read data
  logic re; // last slave error
  int fails = 0;
  int n_checks = 0;
  logic [7:0] cfg [5] = '{8'hD0, 8'h55, 8'hAA, 8'h00, 8'h01};
  logic [79:0] bad [3] = '{80'h1200_0000_0000_0000_0000,
    80'h4F0C_0000_0000_0000_0000, 80'h3C01_0000_0023_0000_0600};

  scd_top #(.NPART(8)) DUT (.CLK_IN(clk), .RST_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OP_DONE_IN(op_done),
    .OP_VALID_OUT(opv), .OP_KIND_OUT(kind), .OP_FILL_OUT(fill),
    .OP_MASK_OUT(mask), .OP_WHOLE_OUT(whole),
    .RETAIN_DEFECTS_OUT(ret), .BUSY_OUT(busy), .DONE_OUT(sdone));

  scd_engine_model eng (.clk_in(clk), .rst_in(rst),
    .op_valid_in(opv), .op_kind_in(kind), .op_fill_in(fill),
    .op_done_out(op_done));

  always #20 clk = ~clk; // 25 MHz

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask

  // one transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 16)
    begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // descriptor bytes 0..9 into the three words, then go
  task automatic cdb(input logic [79:0] c);
    wr(`SCD_A_CDB0, c[79:48]);
    wr(`SCD_A_CDB1, c[47:16]);
    wr(`SCD_A_CDB2, {c[15:0], 16'h0000});
    wr(`SCD_A_CTRL, 32'h0000_0001);
  endtask

  // expected partition reply byte: length header, then records
  function automatic logic [7:0] exp_part(input int i);
    logic [95:0] r;
    int j;
    j = i - 4;
    r = (j / 12 == 1) ? 96'h0001_0001_0000_4000_0000_7FFF : 96'h0;
    if (i < 4)
      return (i == 3) ? 8'h60 : 8'h00;
    if (i >= 28)
      return 8'h00;
    return r[8 * (11 - j % 12) +: 8];
  endfunction

  // one sanitize; engine log and final outputs against expectation
  task automatic san(input logic [79:0] c, input logic [9:0] x[$],
    input logic [9:0] st, input logic twice);
    int b;
    int k;
    b = eng.n_ops;
    cdb(c);
    if (twice)
    begin
      wr(`SCD_A_CTRL, 32'h0000_0001);
      rd(`SCD_A_STAT);
      chk(rq[1:0], 2'b11);
    end
    k = 0;
    while (sdone !== 1'b1 && k < 4000)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 4000)
    begin
      fails++;
      end_sim();
    end
    @(posedge clk);
    chk(eng.n_ops - b, x.size());
    foreach (x[i])
      chk(eng.log_q[(b + i) % 64], x[i]);
    chk({ret, whole, mask}, st);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`SCD_A_DEFCFG);
    chk(rq, 32'h4100_0000);
    rd(8'h80);
    chk(re, 1'b1);
    chk(rq, 32'h0000_0000);
    // partition 1 set up, then two records asked for
    wr(8'h2C, 32'h0001_0001);
    wr(8'h30, 32'h0000_4000);
    wr(8'h34, 32'h0000_7FFF);
    cdb(80'h3C01_0000_0013_0000_1C00);
    rd(`SCD_A_STAT);
    chk(rq[15:8], 8'h1C);
    for (int i = 0; i < 29; i++)
    begin
      rd(`SCD_A_REPLY);
      chk(rq[7:0], exp_part(i));
    end
    san(80'h4F0A_0000_0000_0000_0000, {ER}, 10'h100, 1'b0);
    wr(`SCD_A_DEFCFG, 32'hD055_AA00);
    wr(`SCD_A_DEFRET, 32'h0000_0001);
    cdb(80'h3C01_0000_0023_0000_0500);
    foreach (cfg[i])
    begin
      rd(`SCD_A_REPLY);
      chk(rq[7:0], cfg[i]);
    end
    san(80'h4F0A_0000_0000_0000_0500, {ER, 10'h155, ER, 10'h1AA, ER},
      10'h005, 1'b0);
    san(80'hDF0B_0001_82E5_0000_0000, {ER, RN, ER, RN, ER, RN},
      10'h300, 1'b0);
    san(80'h4F0A_3C00_A5C4_0000_8000, {ER, 10'h1A5, ER, ER, 10'h13C},
      10'h080, 1'b1);
    // two stages only, third argument left at zero
    san(80'h4F0A_0033_0281_0000_0100, {ER, RN, ER, RN, ER, 10'h133},
      10'h001, 1'b0);
    foreach (bad[i])
    begin
      cdb(bad[i]);
      rd(`SCD_A_STAT);
      chk(rq[1:0], 2'b10);
    end
    end_sim();
  end
endmodule

// ### design/scd_defs.svh
/*
  Offsets, opcodes, field positions and reset values for the sanitize
  command decoder. Assumes it is included once per compilation unit by
  any file that needs these names; the guard makes repeats harmless.
*/
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

// apb byte addresses, one aligned word each
`define SCD_A_CDB0 8'h00
`define SCD_A_CDB1 8'h04
`define SCD_A_CDB2 8'h08
`define SCD_A_CTRL 8'h0C
`define SCD_A_STAT 8'h10
`define SCD_A_REPLY 8'h14
`define SCD_A_DEFCFG 8'h18
`define SCD_A_DEFRET 8'h1C
`define SCD_A_PART 8'h20
`define SCD_A_END 8'h80

// command descriptor values
`define SCD_OP_RDBUF 8'h3C
`define SCD_OP_SAN 8'h4F
`define SCD_OP_SAN_OLD 8'hDF
`define SCD_MODE_VEND 5'h01
`define SCD_BOFS_PART 24'h000013
`define SCD_BOFS_CFG 24'h000023
`define SCD_CFG_LEN 24'h000005
`define SCD_ACT_SAN 5'h0A
`define SCD_ACT_KEEP 5'h0B

// reply layout
`define SCD_NPART 8
`define SCD_REC_WORDS 3
`define SCD_HDR_LEN 8'h04
`define SCD_REC_LAST 4'hB
`define SCD_PART_BYTES 8'h60
`define SCD_PART_FULL 8'h64
`define SCD_CFG_BYTES 8'h05
`define SCD_CFG_RET_IDX 8'h04

// stage plan fields and codes
`define SCD_PLAN_CNT 7:6
`define SCD_LOOP_BITS 6:0
`define SCD_SC_FIX 2'h0
`define SCD_SC_RND 2'h1
`define SCD_FACTORY_PLAN 8'h41
`define SCD_FACTORY_PRM 8'h00

// control and status bits
`define SCD_CTRL_GO 0
`define SCD_ST_BUSY 0
`define SCD_ST_ERR 1
`define SCD_ST_KEEP 2
`define SCD_ST_LEFT 15:8

`endif

// ### design/scd_pkg.sv
/*
  Types shared by the sanitize command decoder and its stage sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package scd_pkg;

  // sequencer states, gray along idle-load-erase-fill-next-done
  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_LOAD = 3'h1,
    SQ_ERASE = 3'h3,
    SQ_FILL = 3'h2,
    SQ_NEXT = 3'h6,
    SQ_DONE = 3'h7
  } scd_seq_state_t;

  // media operation handed to the erase engine
  typedef enum logic [1:0] {
    OPK_ERASE = 2'h0,
    OPK_FILL_BYTE = 2'h1,
    OPK_FILL_RND = 2'h2
  } scd_op_t;

  // which reply stream is being read out
  typedef enum logic [1:0] {
    RP_NONE = 2'h0,
    RP_PART = 2'h1,
    RP_CFG = 2'h2
  } scd_reply_t;

endpackage

// ### design/scd_stage_seq.sv
/*
  Stage sequencer: walks up to three erase/fill stages of a stage plan
  and hands one media operation at a time to the erase engine.
  Assumes the engine pulses op_done_in once per accepted operation.
*/
`timescale 1ns/10ps
`include "scd_defs.svh"

module scd_stage_seq
  import scd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [7:0] plan_in,
  input wire logic [7:0] p1_in,
  input wire logic [7:0] p2_in,
  input wire logic [7:0] p3_in,
  input wire logic op_done_in,
  output logic busy_out,
  output logic done_out,
  output logic op_valid_out,
  output scd_op_t op_kind_out,
  output logic [7:0] op_byte_out
);

  scd_seq_state_t state; // sequencer state
  logic [1:0] stage; // stage being run
  logic [6:0] loops; // random fills still to do
  logic [7:0] plan; // latched stage plan
  logic [7:0] prm [3]; // latched stage arguments
  logic [1:0] code; // code of current stage
  logic [7:0] arg; // argument of current stage
  logic op_end; // engine finished an operation

  // stage k code sits at bits 2k+1:2k, argument k belongs to it
  always_comb
  begin
    code = plan[{stage, 1'b0} +: 2];
    arg = prm[stage];
    op_end = op_valid_out & op_done_in;
  end

  // latch the plan; a plan that still says default erases only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      plan <= `SCD_FACTORY_PLAN;
      prm <= '{default: `SCD_FACTORY_PRM};
    end
    else if (start_in && state == SQ_IDLE)
    begin
      if (plan_in[`SCD_PLAN_CNT] == 2'h0)
      begin
        plan <= `SCD_FACTORY_PLAN;
        prm <= '{default: `SCD_FACTORY_PRM};
      end
      else
      begin
        plan <= plan_in;
        prm <= '{p1_in, p2_in, p3_in};
      end
    end
  end

  // stage walk, strictly in stage order
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= SQ_IDLE;
      stage <= 2'h0;
      loops <= 7'h00;
    end
    else
    begin
      unique case (state)
        SQ_IDLE:
          if (start_in)
          begin
            state <= SQ_LOAD;
            stage <= 2'h0;
          end
        SQ_LOAD:
          // field 7:6 limits the plan to three stages
          if (stage == plan[`SCD_PLAN_CNT])
            state <= SQ_DONE;
          else if (code == `SCD_SC_FIX || code == `SCD_SC_RND)
          begin
            state <= SQ_ERASE;
            loops <= arg[`SCD_LOOP_BITS];
          end
          else
            state <= SQ_NEXT;
        SQ_ERASE:
          if (op_end)
            // random stage with zero loops: erase once, no fill
            state <= (code == `SCD_SC_RND && loops == 7'h00) ?
              SQ_NEXT : SQ_FILL;
        SQ_FILL:
          if (op_end)
          begin
            loops <= loops - 7'h01;
            state <= (code == `SCD_SC_RND && loops > 7'h01) ?
              SQ_ERASE : SQ_NEXT;
          end
        SQ_NEXT:
        begin
          stage <= stage + 2'h1;
          state <= SQ_LOAD;
        end
        SQ_DONE:
          state <= SQ_IDLE;
        default:
          state <= SQ_IDLE;
      endcase
    end
  end

  // one operation at a time; a gap cycle between operations
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      op_valid_out <= 1'b0;
      op_kind_out <= OPK_ERASE;
      op_byte_out <= 8'h00;
    end
    else if (op_end)
      op_valid_out <= 1'b0;
    else if (!op_valid_out && state == SQ_ERASE)
    begin
      op_valid_out <= 1'b1;
      op_kind_out <= OPK_ERASE;
    end
    else if (!op_valid_out && state == SQ_FILL)
    begin
      op_valid_out <= 1'b1;
      op_kind_out <= (code == `SCD_SC_FIX) ? OPK_FILL_BYTE
                                           : OPK_FILL_RND;
      op_byte_out <= arg;
    end
  end

  // busy from start to done, done one cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= (state == SQ_DONE);
      if (start_in && state == SQ_IDLE)
        busy_out <= 1'b1;
      else if (state == SQ_DONE)
        busy_out <= 1'b0;
    end
  end

endmodule

// ### design/scd_top.sv
/*
  Sanitize command decoder: takes a command descriptor block over apb,
  answers the partition-settings and configuration reads byte by byte,
  and runs the sanitize stage plan through the erase engine port.
  Assumes an apb master on CLK_IN and an erase engine on the same clock
  that pulses OP_DONE_IN once per operation it finishes.
*/
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/10ps
`include "scd_defs.svh"

// Operation
// - partition read returns twelve bytes per partition
// - four-byte length header precedes partition records
// - config read: offset 0x23, length five
// - config: plan, three arguments, retention flag
// - sanitize descriptor byte layout as documented
// - legacy sanitize opcode also accepted
// - 0x0A sanitizes, 0x0B also keeps defects
// - command arguments override stored defaults
// - plan bits 7:6 give default or stage count
// - code zero: erase, then fill given byte
// - code one: erase and random fill, looped
// - zero loops: erase once, no fill
// - codes two and three do nothing
// - argument n belongs to stage n field
// - mask selects partitions; zero means whole media
// - factory default: erase only, no fill
// - at most three stages per sanitize
// - record: number, flag, start, end sector
// - mask bit n is partition n
module scd_top
  import scd_pkg::*;
#(
  parameter int NPART = `SCD_NPART
)
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic OP_DONE_IN,
  output logic OP_VALID_OUT,
  output scd_op_t OP_KIND_OUT,
  output logic [7:0] OP_FILL_OUT,
  output logic [NPART-1:0] OP_MASK_OUT,
  output logic OP_WHOLE_OUT,
  output logic RETAIN_DEFECTS_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT
);

  localparam int NWORDS = NPART * `SCD_REC_WORDS; // record words

  // bus side
  logic xfer; // access completes at this edge
  logic wr_x; // completing write
  logic rd_x; // completing read
  logic mapped; // address decodes to a register
  logic [31:0] rd_word; // read mux result
  logic [4:0] aidx; // record word picked by address

  // stored settings and descriptor
  logic [31:0] cdb0; // descriptor bytes 0-3, byte 0 high
  logic [31:0] cdb1; // descriptor bytes 4-7
  logic [31:0] cdb2; // descriptor bytes 8-9 in top half
  logic [31:0] def_cfg; // stored plan and arguments
  logic [7:0] def_ret; // stored retention flag byte
  logic [31:0] part_mem [NWORDS]; // partition records

  // descriptor fields
  logic [7:0] opc; // opcode
  logic [4:0] sel; // mode or action selector
  logic [23:0] bofs; // buffer offset
  logic [23:0] alloc; // allocation length
  logic [7:0] c_plan; // plan byte from command
  logic [7:0] c_p1; // stage one argument
  logic [7:0] c_p2; // stage two argument
  logic [7:0] c_p3; // stage three argument
  logic [7:0] c_mask; // partition mask
  logic go; // software asks to execute
  logic is_rd_part; // partition settings read
  logic is_rd_cfg; // configuration read
  logic is_san; // sanitize command

  // command state
  logic cmd_err; // last command refused
  logic seq_start; // launch pulse to sequencer
  logic [7:0] s_plan; // plan handed to sequencer
  logic [7:0] s_p1; // stage one argument
  logic [7:0] s_p2; // stage two argument
  logic [7:0] s_p3; // stage three argument

  // reply stream
  scd_reply_t rp_kind; // stream being read
  logic [7:0] rp_left; // bytes still to read
  logic [7:0] rp_idx; // bytes read so far
  logic [2:0] rec_part; // record being read
  logic [3:0] rec_byte; // byte inside record
  logic [4:0] pidx; // record word of next byte
  logic [31:0] rp_word; // word holding next byte
  logic [1:0] rp_lane; // lane of next byte, 0 is msb
  logic [7:0] rp_byte; // next reply byte

  // descriptor field extraction, big-endian byte order
  always_comb
  begin
    opc = cdb0[31:24];
    sel = cdb0[20:16]; // lun bits 7:5 ignored
    bofs = {cdb0[7:0], cdb1[31:16]};
    alloc = {cdb1[15:0], cdb2[31:24]};
    c_p3 = cdb0[15:8];
    c_p2 = cdb0[7:0];
    c_p1 = cdb1[31:24];
    c_plan = cdb1[23:16];
    c_mask = cdb2[31:24];
  end

  // command classification
  always_comb
  begin
    is_rd_part = opc == `SCD_OP_RDBUF && sel == `SCD_MODE_VEND &&
      bofs == `SCD_BOFS_PART;
    // other lengths are refused rather than truncated
    is_rd_cfg = opc == `SCD_OP_RDBUF && sel == `SCD_MODE_VEND &&
      bofs == `SCD_BOFS_CFG && alloc == `SCD_CFG_LEN;
    is_san = (opc == `SCD_OP_SAN || opc == `SCD_OP_SAN_OLD) &&
      (sel == `SCD_ACT_SAN || sel == `SCD_ACT_KEEP);
  end

  // apb decode; one wait state, answer on the second access cycle
  always_comb
  begin
    xfer = PSEL_IN & PENABLE_IN & PREADY_OUT;
    wr_x = xfer & PWRITE_IN;
    rd_x = xfer & ~PWRITE_IN;
    mapped = PADDR_IN < `SCD_A_END && PADDR_IN[1:0] == 2'h0;
    aidx = 5'(8'(PADDR_IN - `SCD_A_PART) >> 2);
    go = wr_x && PADDR_IN == `SCD_A_CTRL && PWDATA_IN[`SCD_CTRL_GO];
  end

  // read mux; reserved bits read zero
  always_comb
  begin
    rd_word = 32'h0;
    if (PADDR_IN >= `SCD_A_PART)
      rd_word = part_mem[aidx];
    else
    begin
      unique case (PADDR_IN)
        `SCD_A_CDB0: rd_word = cdb0;
        `SCD_A_CDB1: rd_word = cdb1;
        `SCD_A_CDB2: rd_word = cdb2;
        `SCD_A_STAT:
        begin
          rd_word[`SCD_ST_BUSY] = BUSY_OUT;
          rd_word[`SCD_ST_ERR] = cmd_err;
          rd_word[`SCD_ST_KEEP] = RETAIN_DEFECTS_OUT;
          rd_word[`SCD_ST_LEFT] = rp_left;
        end
        `SCD_A_REPLY: rd_word = {24'h0, rp_left != 8'h0 ? rp_byte : 8'h0};
        `SCD_A_DEFCFG: rd_word = def_cfg;
        `SCD_A_DEFRET: rd_word = {24'h0, def_ret};
        default: rd_word = 32'h0; // ctrl reads zero
      endcase
    end
  end

  // bus answer flops; data and error stand with pready
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      PREADY_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      PREADY_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT;
      PSLVERR_OUT <= PSEL_IN & PENABLE_IN & ~PREADY_OUT & ~mapped;
      if (PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN)
        PRDATA_OUT <= mapped ? rd_word : 32'h0;
    end
  end

  // descriptor and stored configuration registers
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      cdb0 <= 32'h0;
      cdb1 <= 32'h0;
      cdb2 <= 32'h0;
      def_cfg <= {`SCD_FACTORY_PLAN, {3{`SCD_FACTORY_PRM}}};
      def_ret <= 8'h00;
    end
    else if (wr_x)
    begin
      unique case (PADDR_IN)
        `SCD_A_CDB0: cdb0 <= PWDATA_IN;
        `SCD_A_CDB1: cdb1 <= PWDATA_IN;
        `SCD_A_CDB2: cdb2 <= PWDATA_IN;
        `SCD_A_DEFCFG: def_cfg <= PWDATA_IN;
        `SCD_A_DEFRET: def_ret <= PWDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  // partition record words; word 0 of each record holds its number
  genvar e;
  generate
    for (e = 0; e < NWORDS; e++)
    begin : g_rec
      localparam logic [31:0] RST_W = (e % `SCD_REC_WORDS == 0) ?
        {16'(e / `SCD_REC_WORDS), 16'h0} : 32'h0;
      always_ff @(posedge CLK_IN)
      begin
        if (RST_IN)
          part_mem[e] <= RST_W;
        else if (wr_x && PADDR_IN == 8'(`SCD_A_PART + 4 * e))
          part_mem[e] <= PWDATA_IN;
      end
    end
  endgenerate

  // command acceptance; refused while a sanitize is running
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      cmd_err <= 1'b0;
      seq_start <= 1'b0;
      s_plan <= 8'h00;
      s_p1 <= 8'h00;
      s_p2 <= 8'h00;
      s_p3 <= 8'h00;
      OP_MASK_OUT <= '0;
      OP_WHOLE_OUT <= 1'b1;
      RETAIN_DEFECTS_OUT <= 1'b0;
    end
    else
    begin
      seq_start <= go & is_san & ~BUSY_OUT;
      if (go)
        cmd_err <= BUSY_OUT | ~(is_rd_part | is_rd_cfg | is_san);
      if (go && is_san && !BUSY_OUT)
      begin
        // a nonzero count in the command overrides stored defaults
        if (c_plan[`SCD_PLAN_CNT] != 2'h0)
        begin
          s_plan <= c_plan;
          {s_p1, s_p2, s_p3} <= {c_p1, c_p2, c_p3};
        end
        else
        begin
          s_plan <= def_cfg[31:24];
          {s_p1, s_p2, s_p3} <= def_cfg[23:0];
        end
        OP_MASK_OUT <= NPART'(c_mask);
        OP_WHOLE_OUT <= c_mask == 8'h00;
        RETAIN_DEFECTS_OUT <= sel == `SCD_ACT_KEEP;
      end
    end
  end

  // reply stream; each read of the reply register takes one byte
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      rp_kind <= RP_NONE;
      rp_left <= 8'h00;
      rp_idx <= 8'h00;
      rec_part <= 3'h0;
      rec_byte <= 4'h0;
    end
    else if (go && !BUSY_OUT && (is_rd_part || is_rd_cfg))
    begin
      rp_kind <= is_rd_part ? RP_PART : RP_CFG;
      rp_idx <= 8'h00;
      rec_part <= 3'h0;
      rec_byte <= 4'h0;
      if (is_rd_cfg)
        rp_left <= `SCD_CFG_BYTES;
      // the host sizes the read; never past the last record
      else if (alloc > 24'(`SCD_PART_FULL))
        rp_left <= `SCD_PART_FULL;
      else
        rp_left <= alloc[7:0];
    end
    else if (rd_x && PADDR_IN == `SCD_A_REPLY && rp_left != 8'h0)
    begin
      rp_left <= rp_left - 8'h01;
      rp_idx <= rp_idx + 8'h01;
      if (rp_kind == RP_PART && rp_idx >= `SCD_HDR_LEN)
      begin
        if (rec_byte == `SCD_REC_LAST)
        begin
          rec_byte <= 4'h0;
          rec_part <= rec_part + 3'h1;
        end
        else
          rec_byte <= rec_byte + 4'h1;
      end
    end
  end

  // next reply byte: header, then records, or the config record
  always_comb
  begin
    pidx = {1'b0, rec_part, 1'b0} + {2'h0, rec_part} +
      {3'h0, rec_byte[3:2]};
    rp_word = 32'h0;
    rp_lane = rp_idx[1:0];
    unique case (rp_kind)
      RP_PART:
        if (rp_idx < `SCD_HDR_LEN)
          rp_word = {24'h0, `SCD_PART_BYTES};
        else
        begin
          rp_word = part_mem[pidx];
          rp_lane = rec_byte[1:0];
        end
      RP_CFG:
        if (rp_idx == `SCD_CFG_RET_IDX)
          rp_word = {def_ret, 24'h0};
        else
          rp_word = def_cfg;
      default: rp_word = 32'h0;
    endcase
    unique case (rp_lane)
      2'h0: rp_byte = rp_word[31:24];
      2'h1: rp_byte = rp_word[23:16];
      2'h2: rp_byte = rp_word[15:8];
      default: rp_byte = rp_word[7:0];
    endcase
  end

  // stage walker; its outputs are its own flops
  scd_stage_seq u_seq (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .start_in(seq_start),
    .plan_in(s_plan),
    .p1_in(s_p1),
    .p2_in(s_p2),
    .p3_in(s_p3),
    .op_done_in(OP_DONE_IN),
    .busy_out(BUSY_OUT),
    .done_out(DONE_OUT),
    .op_valid_out(OP_VALID_OUT),
    .op_kind_out(OP_KIND_OUT),
    .op_byte_out(OP_FILL_OUT)
  );

endmodule
